// [logic/mdu_consts.vh]
// Constants for the multiply/divide unit
`ifndef MDU_CONSTS_VH
`define MDU_CONSTS_VH
// Operation codes presented by the integer pipeline
`define MDU_OP_W        3
`define MDU_OP_PAIR     3'h0
`define MDU_OP_ACC      3'h1
`define MDU_OP_SUB      3'h2
`define MDU_OP_TOREG    3'h3
`define MDU_OP_DIV      3'h4
// Booth multiplier shape
`define MDU_A_W         32
`define MDU_B_W         16
`define MDU_PP_W        48
// Divider iteration counts
`define MDU_DIV_FULL    6'h20
`define MDU_SKIP_8      6'h17
`define MDU_SKIP_16     6'h0F
`define MDU_SKIP_24     6'h07
`define MDU_CNT_W       6
// The issue edge counts as the first divide cycle
`define MDU_DIV_XTRA    6'h01
// Divide latency by dividend width, issue edge included
`define MDU_DIV_LAT_8   6'h0C
`define MDU_DIV_LAT_16  6'h13
`define MDU_DIV_LAT_24  6'h1A
`define MDU_DIV_LAT_32  6'h21
`endif

// [logic/mdu_booth_mul.v]
// Radix-4 Booth-recoded 32x16 signed partial product stage
`timescale 1ns/1ns
module mdu_booth_mul (
  input  wire [31:0] mcand,
  input  wire [16:0] mplier,
  output reg  [48:0] prod
);
  // mplier is a 17-bit signed value so unsigned 16-bit halves also fit
  integer i;
  reg [2:0]  grp;
  reg [49:0] pp;
  reg [49:0] acc;
  reg [49:0] mc_ext;
  always @* begin
    acc = 50'h0;
    pp = 50'h0;
    grp = 3'h0;
    mc_ext = {{18{mcand[31]}}, mcand};
    for (i = 0; i < 9; i = i + 1) begin
      if (i == 0)
        grp = {mplier[1:0], 1'b0};
      else if (i == 8)
        grp = {mplier[16], mplier[16], mplier[15]};
      else
        grp = mplier[2*i+1 -: 3];
      case (grp)
        3'h1, 3'h2: pp = mc_ext;
        3'h3:       pp = mc_ext << 1;
        3'h4:       pp = -(mc_ext << 1);
        3'h5, 3'h6: pp = -mc_ext;
        default:    pp = 50'h0;
      endcase
      acc = acc + (pp << (2 * i));
    end
    prod = acc[48:0];
  end
endmodule // mdu_booth_mul

// [logic/mdu_core.v]
// Multiply/divide unit: Booth multiplier, result registers, iterative divider
// Functional notes
// - Own pipeline keeps advancing whatever the integer pipeline stall state.
// - Booth 32x16 multiplier, operand_a wide input, operand_b narrow input.
// - Pass count set by operand_b width: one pass, or two for 32x32.
// - Short multiply every cycle; back-to-back 32x32 stalls issue one cycle.
// - Operand size detected internally from operand values.
// - Divide resolves one quotient bit per clock.
// - Early-in skips 23, 15 or 7 iterations by dividend width.
// - Any unit instruction during an active divide stalls the pipeline.
// - Multiply latency/repeat 1/1, 2/2; to-register 2/1, 3/2.
// - Divide latency/repeat 12/12, 19/19, 26/26, 33/33.
`timescale 1ns/1ns
`include "mdu_consts.vh"
module mdu_core (
  input  wire        clock,
  input  wire        rstn,
  input  wire        issue_valid,
  input  wire [2:0]  issue_op,
  input  wire        issue_signed,
  input  wire [31:0] operand_a,
  input  wire [31:0] operand_b,
  output reg         issue_stall_ff,
  output reg  [31:0] result_top_ff,
  output reg  [31:0] result_bottom_ff,
  output reg         result_valid_ff,
  output reg         gpr_valid_ff,
  output reg  [31:0] gpr_data_ff,
  output reg         busy_ff
);
  localparam ST_IDLE = 3'h1;
  localparam ST_MUL2 = 3'h2;
  localparam ST_DIV  = 3'h4;

  reg [2:0]  state_ff;
  reg [2:0]  op_ff;
  reg        sgn_ff;
  reg [31:0] a_ff;
  reg [31:0] b_hi_ff;
  reg [63:0] part_ff;
  reg        toreg_ff;
  reg [5:0]  cnt_ff;
  reg [31:0] rem_ff;
  reg [31:0] quo_ff;
  reg [31:0] dvs_ff;
  reg        qneg_ff;
  reg        rneg_ff;
  reg [5:0]  tail_ff;
  reg        tr_pend_ff;
  reg [31:0] tr_data_ff;

  // True when a value is a sign/zero extension of its low n bits
  function fits;
    input [31:0] v;
    input [5:0]  n;
    input        s;
    reg   [31:0] ext;
    begin
      ext = s ? (v[31] ? ~v : v) : v;
      fits = ((ext >> (n - ((s) ? 6'h01 : 6'h00))) == 32'h0);
    end
  endfunction

  function [31:0] absval;
    input [31:0] v;
    input        s;
    begin
      absval = (s && v[31]) ? (~v + 32'h1) : v;
    end
  endfunction

  // Size decided from the operand values and issue_signed
  wire b_short = fits(operand_b, 6'h10, issue_signed);
  wire is_div  = (issue_op == `MDU_OP_DIV);
  wire busy_now = (state_ff != ST_IDLE);
  // Stall while a divide or second pass occupies the unit
  wire stall_c = issue_valid && busy_now;
  wire take    = issue_valid && !busy_now;

  // Booth array shared by both passes
  reg  [31:0] m_a;
  reg  [16:0] m_b;
  wire [48:0] m_prod;
  always @* begin
    m_a = a_ff;
    m_b = {1'b0, b_hi_ff[15:0]};
    if (state_ff == ST_IDLE) begin
      m_a = operand_a;
      m_b = {issue_signed & operand_b[15] & b_short, operand_b[15:0]};
    end else if (state_ff == ST_MUL2) begin
      m_b = {sgn_ff & b_hi_ff[31], b_hi_ff[31:16]};
    end
  end
  mdu_booth_mul u_mul (
    .mcand  (m_a),
    .mplier (m_b),
    .prod   (m_prod)
  );

  // Unsigned 32-bit a needs an extra correction for bit 31
  wire [63:0] pass_val = {{15{m_prod[48]}}, m_prod}
    + ((!(state_ff == ST_IDLE ? issue_signed : sgn_ff) && m_a[31])
       ? ({47'h0, m_b} << 32) : 64'h0);

  // Full product after first or second pass
  wire [63:0] prod_final = (state_ff == ST_MUL2) ? (part_ff + (pass_val << 16)) : pass_val;

  // Combine product into result registers
  function [63:0] merge;
    input [2:0]  op;
    input [63:0] cur;
    input [63:0] p;
    begin
      case (op)
        `MDU_OP_ACC: merge = cur + p;
        `MDU_OP_SUB: merge = cur - p;
        default:     merge = p;
      endcase
    end
  endfunction

  wire [63:0] cur_hl = {result_top_ff, result_bottom_ff};
  wire fit8  = fits(operand_a, 6'h08, issue_signed);
  wire fit16 = fits(operand_a, 6'h10, issue_signed);
  wire fit24 = fits(operand_a, 6'h18, issue_signed);
  wire [5:0] skip = fit8 ? `MDU_SKIP_8 : fit16 ? `MDU_SKIP_16 :
                    fit24 ? `MDU_SKIP_24 : 6'h00;
  // Loop length by width; skips and latencies do not step alike, so a tail pads
  wire [5:0] div_len = (fit8 ? `MDU_DIV_LAT_8 : fit16 ? `MDU_DIV_LAT_16 :
                        fit24 ? `MDU_DIV_LAT_24 : `MDU_DIV_LAT_32) - `MDU_DIV_XTRA;
  wire [31:0] a_mag = absval(operand_a, issue_signed);
  // Extra top bit keeps the borrow honest for divisors above half range
  wire [33:0] trial = {1'b0, rem_ff, quo_ff[31]} - {2'h0, dvs_ff};
  // Shift one quotient bit while bits remain, then idle out the tail
  wire        div_step = (cnt_ff > tail_ff);
  wire [31:0] nxt_rem  = !div_step ? rem_ff :
                         trial[33] ? {rem_ff[30:0], quo_ff[31]} : trial[31:0];
  wire [31:0] nxt_quo  = div_step ? {quo_ff[30:0], ~trial[33]} : quo_ff;

  // Unit pipeline; never looks at integer-side stalls
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      op_ff <= 3'h0;
      sgn_ff <= 1'b0;
      a_ff <= 32'h0;
      b_hi_ff <= 32'h0;
      part_ff <= 64'h0;
      toreg_ff <= 1'b0;
      cnt_ff <= 6'h0;
      rem_ff <= 32'h0;
      quo_ff <= 32'h0;
      dvs_ff <= 32'h0;
      qneg_ff <= 1'b0;
      rneg_ff <= 1'b0;
      tail_ff <= 6'h00;
      issue_stall_ff <= 1'b0;
      result_top_ff <= 32'h0;
      result_bottom_ff <= 32'h0;
      result_valid_ff <= 1'b0;
      gpr_valid_ff <= 1'b0;
      gpr_data_ff <= 32'h0;
      busy_ff <= 1'b0;
      tr_pend_ff <= 1'b0;
      tr_data_ff <= 32'h0;
    end else begin
      result_valid_ff <= 1'b0;
      // To-register word leaves one stage after the pair result
      gpr_valid_ff <= tr_pend_ff;
      if (tr_pend_ff)
        gpr_data_ff <= tr_data_ff;
      tr_pend_ff <= 1'b0;
      issue_stall_ff <= stall_c;
      case (state_ff)
        ST_IDLE: begin
          if (take && is_div) begin
            // Pre-shift dividend past skipped bits
            op_ff <= issue_op;
            dvs_ff <= absval(operand_b, issue_signed);
            quo_ff <= a_mag << skip;
            rem_ff <= 32'h0;
            cnt_ff <= div_len;
            qneg_ff <= issue_signed & (operand_a[31] ^ operand_b[31]);
            rneg_ff <= issue_signed & operand_a[31];
            tail_ff <= div_len - (`MDU_DIV_FULL - skip);
            state_ff <= ST_DIV;
          end else if (take && !b_short) begin
            // First of two passes for 32x32
            op_ff <= issue_op;
            sgn_ff <= issue_signed;
            a_ff <= operand_a;
            b_hi_ff <= operand_b;
            part_ff <= pass_val;
            toreg_ff <= (issue_op == `MDU_OP_TOREG);
            state_ff <= ST_MUL2;
          end else if (take) begin
            {result_top_ff, result_bottom_ff} <= merge(issue_op, cur_hl, prod_final);
            result_valid_ff <= 1'b1;
            // To-register result one cycle later than the pair result
            tr_pend_ff <= (issue_op == `MDU_OP_TOREG);
            tr_data_ff <= prod_final[31:0];
          end
        end
        ST_MUL2: begin
          {result_top_ff, result_bottom_ff} <= merge(op_ff, cur_hl, prod_final);
          result_valid_ff <= 1'b1;
          tr_pend_ff <= toreg_ff;
          tr_data_ff <= prod_final[31:0];
          state_ff <= ST_IDLE;
        end
        ST_DIV: begin
          cnt_ff <= cnt_ff - 6'h01;
          // One quotient bit per clock
          rem_ff <= nxt_rem;
          quo_ff <= nxt_quo;
          if (cnt_ff == `MDU_DIV_XTRA) begin
            // Sign fix-up on the final cycle, with the last bit for 24/32-bit dividends; remainder to top
            result_top_ff <= rneg_ff ? (~nxt_rem + 32'h1) : nxt_rem;
            result_bottom_ff <= qneg_ff ? (~nxt_quo + 32'h1) : nxt_quo;
            result_valid_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
      busy_ff <= (state_ff == ST_IDLE) ? (take && (is_div || !b_short)) :
                 (state_ff == ST_DIV && cnt_ff != `MDU_DIV_XTRA);
    end
  end
endmodule // mdu_core

// [sim/mdu_core_sva.sv]
// Port checker for the multiply/divide unit
`timescale 1ns/1ns
module mdu_chk (
  input logic        clock,
  input logic        rstn,
  input logic        issue_valid,
  input logic [2:0]  issue_op,
  input logic        issue_signed,
  input logic [31:0] operand_a,
  input logic [31:0] operand_b,
  input logic        issue_stall_ff,
  input logic        result_valid_ff,
  input logic        gpr_valid_ff,
  input logic        busy_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Accepted requests; widths judged on unsigned ones only
  wire go  = issue_valid && !busy_ff;
  wire mul = go && !issue_signed && issue_op < 3'h3;
  wire dv  = go && !issue_signed && issue_op == 3'h4;
  wire trg = go && !issue_signed && issue_op == 3'h3 && operand_b[31:16] == 16'h0;
  a_mul_short: assert property (mul && operand_b[31:16] == 16'h0 |=> result_valid_ff)
    else $error("short product late");
  a_mul_long: assert property (mul && operand_b[31] |=>
    (busy_ff && !result_valid_ff) ##1 result_valid_ff) else $error("long product timing");
  a_stall_busy: assert property (issue_valid && busy_ff |=> issue_stall_ff)
    else $error("no stall");
  a_no_stall: assert property (go |=> !issue_stall_ff)
    else $error("bad stall");
  a_div_byte: assert property (dv && operand_a[31:8] == 24'h0 |=>
    (busy_ff && !result_valid_ff)[*8] ##1 (busy_ff && !result_valid_ff)[*3] ##1 result_valid_ff)
    else $error("byte divide");
  a_div_half: assert property (dv && operand_a[31:16] == 16'h0 && operand_a[15:8] != 8'h0
    |-> ##19 result_valid_ff) else $error("half divide");
  a_div_word: assert property (dv && operand_a[31] |-> ##33 result_valid_ff)
    else $error("word divide");
  a_toreg_late: assert property (trg |-> ##2 gpr_valid_ff)
    else $error("to-register word timing");
  a_div_busy: assert property (dv |=> busy_ff)
    else $error("divide not busy");
endmodule // mdu_chk
bind mdu_core mdu_chk chk (.*);

// [sim/mdu_pipe.sv]
// Issuing pipeline model for the multiply/divide unit
`timescale 1ns/1ns
module mdu_pipe (
  input  logic        clock,
  input  logic        issue_stall_ff,
  input  logic        busy_ff,
  output logic        issue_valid,
  output logic [2:0]  issue_op,
  output logic        issue_signed,
  output logic [31:0] operand_a,
  output logic [31:0] operand_b
);
  logic retried;
  // Quiet at time zero
  initial {issue_valid, issue_op, issue_signed, operand_a, operand_b} = '0;
  // n ops back to back; the last op, if refused, is shown again once the unit is free
  task automatic issue(input logic [2:0] op, input logic s, input logic [31:0] a,
                       input logic [31:0] b, input int n);
    retried = 1'b0;
    repeat (n) begin
      @(posedge clock) #1;
      {issue_valid, issue_op, issue_signed, operand_a, operand_b} = {1'b1, op, s, a, b};
      a = a + 32'h1;
    end
    do begin
      @(posedge clock) #1;
      issue_valid = 1'b0;
      {operand_a, operand_b} = ~{operand_a, operand_b}; // Released lines do not hold
      if (!issue_stall_ff) break;
      retried = 1'b1;
      do @(posedge clock) #1; while (busy_ff);
      {issue_valid, operand_a, operand_b} = {1'b1, a - 32'h1, b};
    end while (1);
  endtask
endmodule // mdu_pipe

// [sim/tb_multiply_divide_unit.sv]
// Self-checking bench for the multiply/divide unit
`timescale 1ns/1ns
module tb_multiply_divide_unit;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        issue_valid, issue_signed, issue_stall_ff, result_valid_ff, gpr_valid_ff, busy_ff;
  logic [2:0]  issue_op;
  logic [31:0] operand_a, operand_b, result_top_ff, result_bottom_ff, gpr_data_ff;
  logic [63:0] acc, e;
  int          mismatches, samples_checked;
  // Rows: {op, signed}, operand_a, operand_b
  logic [67:0] rows [8] = '{68'h0_00001234_00005678, 68'h3_FFFFFFFD_00000007,
    68'h4_00010000_0000FFFF, 68'h0_FFFFFFFF_80000001, 68'h8_000000C8_00000007,
    68'h8_0000C350_00000007, 68'h9_FFEDCBAA_00000010, 68'h6_00012345_00000011};
  mdu_core DUT (.*);
  mdu_pipe pipe (.*);
  always #5 clock = ~clock;
  // Expected pair, worked out apart from the unit
  function automatic logic [63:0] model(input logic [67:0] r);
    logic [63:0] p;
    logic signed [31:0] q, m;
    p = r[64] ? {{32{r[63]}}, r[63:32]} * {{32{r[31]}}, r[31:0]} : r[63:32] * r[31:0];
    q = $signed(r[63:32]) / $signed(r[31:0]);
    m = $signed(r[63:32]) % $signed(r[31:0]);
    case (r[67:65])
      3'h1: return acc + p;
      3'h2: return acc - p;
      3'h4: return r[64] ? {m, q} : {r[63:32] % r[31:0], r[63:32] / r[31:0]};
      default: return p;
    endcase
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a result pulse
  task automatic wait_res(input logic g);
    int n;
    n = 0;
    while ((g ? gpr_valid_ff : result_valid_ff) !== 1'b1 && n < 60) begin
      @(posedge clock) #1;
      n++;
    end
    chk({63'h0, n < 60}, 64'h1);
  endtask
  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Reset, table of cases, then the awkward ones
  initial begin
    repeat (6) @(posedge clock);
    #1 chk({busy_ff, result_valid_ff, issue_stall_ff, result_top_ff[28:0], result_bottom_ff}, 64'h0);
    chk({gpr_valid_ff, 31'h0, gpr_data_ff}, 64'h0);
    repeat (6) @(posedge clock);
    #1 rstn = 1'b1;
    acc = 64'h0;
    for (int i = 0; i < 8; i++) begin
      e = model(rows[i]);
      pipe.issue(rows[i][67:65], rows[i][64], rows[i][63:32], rows[i][31:0], 1);
      wait_res(rows[i][67:65] == 3'h3);
      if (rows[i][67:65] == 3'h3)
        chk({32'h0, gpr_data_ff}, {32'h0, e[31:0]});
      else
        chk({result_top_ff, result_bottom_ff}, e);
      acc = (rows[i][67:65] == 3'h3) ? acc : e;
    end
    pipe.issue(3'h0, 1'b0, 32'h00000010, 32'h00000003, 2);
    chk({result_bottom_ff, 31'h0, pipe.retried}, {32'h33, 32'h0});
    pipe.issue(3'h0, 1'b0, 32'hFFFFFFF0, 32'h80000000, 2);
    wait_res(1'b0);
    chk({result_top_ff, result_bottom_ff}, model(68'h0_FFFFFFF1_80000000));
    chk({63'h0, pipe.retried}, 64'h1);
    pipe.issue(3'h4, 1'b0, 32'h92345678, 32'h00000007, 1);
    pipe.issue(3'h0, 1'b0, 32'h00000005, 32'h00000006, 1);
    wait_res(1'b0);
    chk({result_bottom_ff, 31'h0, pipe.retried}, {32'h1E, 32'h1});
    // Second reset in the middle of a divide
    pipe.issue(3'h4, 1'b0, 32'hF0000000, 32'h00000003, 1);
    repeat (4) @(posedge clock);
    #1 rstn = 1'b0;
    #1 chk({busy_ff, result_valid_ff, issue_stall_ff, result_top_ff[28:0], result_bottom_ff}, 64'h0);
    chk({gpr_valid_ff, 31'h0, gpr_data_ff}, 64'h0);
    // Work resumes after the second release
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    pipe.issue(3'h0, 1'b1, 32'hFFFFFFFE, 32'h00000003, 1);
    wait_res(1'b0);
    chk({result_top_ff, result_bottom_ff}, model(68'h1_FFFFFFFE_00000003));
    final_report;
  end
  // Watchdog well past the expected run
  initial begin
    #20000;
    mismatches++;
    final_report;
  end
endmodule // tb_multiply_divide_unit
